// ### core/iqr_regs.v
`include "iqr_defs.vh"

module iqr_regs #(
    parameter        QI_SUPPORT  = 1,   // queued invalidation implemented
    parameter        SMT_SUPPORT = 0,   // scalable_translation_support
    parameter        ADM_SUPPORT = 0,   // abort_dma_support
    parameter        HOST_ADDRESS_WIDTH         = 48   // host_address_width
) (
    input  wire        mclk,         // clock, 50 MHz
    input  wire        nrst,         // sync reset, active low
    input  wire        hsel,         // ahb slave select
    input  wire [31:0] haddr,        // ahb address
    input  wire [1:0]  htrans,       // ahb transfer type
    input  wire        hwrite,       // ahb write
    input  wire [2:0]  hsize,        // ahb size
    input  wire [31:0] hwdata,       // ahb write data
    input  wire        hready,       // ahb bus ready
    output reg  [31:0] hrdata,       // ahb read data
    output wire        hreadyout,    // ahb slave ready
    output wire        hresp,        // ahb response, always okay
    input  wire        desc_take,    // fetch engine consumed one descriptor
    input  wire        wait_done_if, // wait descriptor with irq flag completed
    output wire        fetch_req,    // descriptors pending (head != tail) while queue enabled and no queue error
    output wire [63:0] fetch_addr,   // address of descriptor at head
    output wire        queue_error,  // invalidation queue error level
    output wire        wait_done_new // new interrupt condition pulse
);
    reg  [14:0] tail_offset_ff;
    reg  [51:0] queue_base_address_ff;
    reg         descriptor_width_ff;
    reg  [2:0]  queue_size_log_ff;
    reg         wait_done_flag_ff;
    reg         enable_ff;
    reg         err_tail_ff;
    reg         err_dw_ff;
    reg         wnew_ff;
    reg  [63:0] fetch_addr_ff;

    reg         dph_wr_ff;
    reg         dph_rd_ff;
    reg  [7:0]  dph_addr_ff;

    reg  [14:0] nxt_tail;
    reg  [51:0] nxt_base;
    reg         nxt_dw;
    reg  [2:0]  nxt_qs;
    reg         nxt_wdone;
    reg         nxt_en;
    reg         nxt_err_tail;
    reg         nxt_err_dw;
    reg  [31:0] rd_mux;

    wire [14:0] head_offset;
    wire        empty;
    wire        addr_phase;
    wire [51:0] base_mask;
    wire [63:0] base_full;
    wire        dw_allowed;
    wire        qi_on;

    localparam [0:0] QI_ON = QI_SUPPORT ? 1'b1 : 1'b0;
    localparam [0:0] DW_OK = (SMT_SUPPORT || ADM_SUPPORT) ? 1'b1 : 1'b0;

    assign qi_on      = QI_ON;
    assign dw_allowed = DW_OK;

    // bits at/above HOST_ADDRESS_WIDTH are not stored, hence read back as zero
    genvar gi;
    generate
        for (gi = 0; gi < 52; gi = gi + 1) begin : g_mask
            assign base_mask[gi] = ((gi + `IQR_BASE_LO_LSB) < HOST_ADDRESS_WIDTH) ? 1'b1 : 1'b0;
        end
    endgenerate

    assign base_full = {queue_base_address_ff, 12'h000};

    iqr_head_ctr u_head (
        .mclk    (mclk),
        .nrst    (nrst),
        .enable  (enable_ff),
        .dw_256  (descriptor_width_ff),
        .qs      (queue_size_log_ff),
        .tail    (tail_offset_ff),
        .advance (desc_take),
        .head    (head_offset),
        .empty   (empty)
    );

    // fetching stops on any queue error
    assign fetch_req   = enable_ff && !empty && !queue_error;
    assign fetch_addr  = fetch_addr_ff;
    assign queue_error = err_tail_ff || err_dw_ff;
    assign wait_done_new = wnew_ff;

    // one wait state on reads, so a write just ahead of the read is already visible
    assign hreadyout = !dph_rd_ff;
    assign hresp     = 1'b0;
    assign addr_phase = hsel && hready && htrans[1];

    // ahb data phase bookkeeping
    always @(posedge mclk) begin
        if (!nrst) begin
            dph_wr_ff   <= 1'b0;
            dph_rd_ff   <= 1'b0;
            dph_addr_ff <= 8'h00;
        end else begin
            dph_rd_ff <= addr_phase && !hwrite;
            if (hready) begin
                dph_wr_ff   <= addr_phase && hwrite;
                dph_addr_ff <= {haddr[7:2], 2'b00};
            end
        end
    end

    always @* begin
        nxt_tail     = tail_offset_ff;
        nxt_base     = queue_base_address_ff;
        nxt_dw       = descriptor_width_ff;
        nxt_qs       = queue_size_log_ff;
        nxt_en       = enable_ff;
        nxt_wdone    = wait_done_flag_ff;
        nxt_err_tail = err_tail_ff;
        nxt_err_dw   = err_dw_ff;
        if (dph_wr_ff && qi_on) begin
            case (dph_addr_ff)
                `IQR_OFF_TAIL_LO: begin
                    nxt_tail = hwdata[`IQR_OFS_MSB:`IQR_OFS_LSB];
                end
                `IQR_OFF_BASE_LO: begin
                    nxt_base[19:0] = hwdata[31:`IQR_BASE_LO_LSB] & base_mask[19:0];
                    nxt_dw = hwdata[`IQR_DW_BIT];
                    nxt_qs = hwdata[`IQR_QS_MSB:0];
                end
                `IQR_OFF_BASE_HI: begin
                    nxt_base[51:20] = hwdata & base_mask[51:20];
                end
                `IQR_OFF_CMPL: begin
                    if (hwdata[`IQR_WDONE_BIT]) begin
                        nxt_wdone = 1'b0;
                    end
                end
                `IQR_OFF_CTRL: begin
                    nxt_en = hwdata[`IQR_CTRL_EN_BIT];
                    if (!hwdata[`IQR_CTRL_EN_BIT]) begin
                        nxt_err_tail = 1'b0;
                        nxt_err_dw   = 1'b0;
                    end
                end
                default: begin
                    nxt_en = enable_ff;
                end
            endcase
        end
        // checks on the values being written, so fetch never starts on a bad setup
        if (nxt_en && nxt_dw && nxt_tail[0]) begin
            nxt_err_tail = 1'b1;
        end
        if (nxt_en && nxt_dw && !dw_allowed) begin
            nxt_err_dw = 1'b1;
        end
        // set wins over a same-cycle clear
        if (wait_done_if && qi_on) begin
            nxt_wdone = 1'b1;
        end
    end

    always @(posedge mclk) begin
        if (!nrst) begin
            tail_offset_ff        <= `IQR_RST_OFS;
            queue_base_address_ff <= 52'h0;
            descriptor_width_ff   <= 1'b0;
            queue_size_log_ff     <= `IQR_RST_QS;
            wait_done_flag_ff     <= 1'b0;
            enable_ff             <= 1'b0;
            err_tail_ff           <= 1'b0;
            err_dw_ff             <= 1'b0;
            wnew_ff               <= 1'b0;
            fetch_addr_ff         <= `IQR_RST_64;
        end else begin
            tail_offset_ff        <= nxt_tail;
            queue_base_address_ff <= nxt_base;
            descriptor_width_ff   <= nxt_dw;
            queue_size_log_ff     <= nxt_qs;
            wait_done_flag_ff     <= nxt_wdone;
            enable_ff             <= nxt_en;
            err_tail_ff           <= nxt_err_tail;
            err_dw_ff             <= nxt_err_dw;
            // flag already set: not a fresh condition
            wnew_ff <= wait_done_if && qi_on && !wait_done_flag_ff;
            fetch_addr_ff <= base_full + {45'h0, head_offset, 4'h0};
        end
    end

    always @* begin
        rd_mux = 32'h0;
        case (dph_addr_ff)
            `IQR_OFF_HEAD_LO: rd_mux = {13'h0, head_offset, 4'h0};
            `IQR_OFF_TAIL_LO: rd_mux = {13'h0, tail_offset_ff, 4'h0};
            `IQR_OFF_BASE_LO: rd_mux = {queue_base_address_ff[19:0], descriptor_width_ff,
                                        8'h00, queue_size_log_ff};
            `IQR_OFF_BASE_HI: rd_mux = queue_base_address_ff[51:20];
            `IQR_OFF_CMPL:    rd_mux = {31'h0, wait_done_flag_ff};
            `IQR_OFF_CTRL:    rd_mux = {31'h0, enable_ff};
            `IQR_OFF_STAT:    rd_mux = {29'h0, empty, queue_error, enable_ff};
            default:          rd_mux = 32'h0;
        endcase
    end

    // loaded at the end of the wait state, stands until the next read
    always @(posedge mclk) begin
        if (!nrst) begin
            hrdata <= 32'h0;
        end else if (addr_phase && !hwrite) begin
            hrdata <= 32'h0;
        end else if (dph_rd_ff) begin
            hrdata <= qi_on ? rd_mux : 32'h0;
        end
    end
endmodule

// ### core/iqr_defs.vh
`ifndef IQR_DEFS_VH
`define IQR_DEFS_VH

// byte addresses of 32-bit words (64-bit registers take two words)
`define IQR_OFF_HEAD_LO   8'h80
`define IQR_OFF_HEAD_HI   8'h84
`define IQR_OFF_TAIL_LO   8'h88
`define IQR_OFF_TAIL_HI   8'h8c
`define IQR_OFF_BASE_LO   8'h90
`define IQR_OFF_BASE_HI   8'h94
`define IQR_OFF_CMPL      8'h9c
`define IQR_OFF_CTRL      8'ha0
`define IQR_OFF_STAT      8'ha4

// field positions
`define IQR_OFS_MSB       18
`define IQR_OFS_LSB       4
`define IQR_BASE_LO_LSB   12
`define IQR_DW_BIT        11
`define IQR_QS_MSB        2
`define IQR_WDONE_BIT     0

// control register bits
`define IQR_CTRL_EN_BIT   0
// status register bits
`define IQR_ST_EN_BIT     0
`define IQR_ST_ERR_BIT    1
`define IQR_ST_EMPTY_BIT  2

// reset values
`define IQR_RST_64        64'h0
`define IQR_RST_OFS       15'h0000
`define IQR_RST_QS        3'h0

// entry counts: 2^(qs+8) for 128-bit, 2^(qs+7) for 256-bit
`define IQR_ENT_LOG_128   4'h8
`define IQR_ENT_LOG_256   4'h7

// ahb codes
`define IQR_HTRANS_NONSEQ 2'h2
`define IQR_HTRANS_SEQ    2'h3

`endif

// ### core/iqr_head_ctr.v
`include "iqr_defs.vh"

module iqr_head_ctr (
    input  wire        mclk,         // clock
    input  wire        nrst,         // sync reset, active low
    input  wire        enable,       // queued invalidation enabled
    input  wire        dw_256,       // 256-bit descriptors
    input  wire [2:0]  qs,           // queue size log
    input  wire [14:0] tail,         // tail offset, 16-byte units
    input  wire        advance,      // one descriptor consumed
    output wire [14:0] head,         // head offset, 16-byte units
    output wire        empty         // head equals tail
);
    reg  [14:0] head_ff;
    reg  [14:0] nxt_head;
    wire [3:0]  ent_log;
    wire [15:0] limit;
    wire [15:0] step;
    wire [15:0] sum;

    // queue length in 16-byte units is 2^(qs+8) either way
    assign ent_log = dw_256 ? `IQR_ENT_LOG_256 : `IQR_ENT_LOG_128;
    assign limit   = 16'h0001 << (ent_log + {1'b0, qs} + {3'h0, dw_256});
    assign step    = dw_256 ? 16'h0002 : 16'h0001;
    assign sum     = {1'b0, head_ff} + step;

    assign empty = (head_ff == tail);
    assign head  = head_ff;

    always @* begin
        nxt_head = head_ff;
        if (!enable) begin
            nxt_head = `IQR_RST_OFS;
        end else if (advance && !empty) begin
            nxt_head = (sum >= limit) ? `IQR_RST_OFS : sum[14:0];
        end
    end

    always @(posedge mclk) begin
        if (!nrst) begin
            head_ff <= `IQR_RST_OFS;
        end else begin
            head_ff <= nxt_head;
        end
    end
endmodule

// ### tb/iqr_regs_sva.sv
module iqr_regs_sva (
    input wire        mclk,          // clock
    input wire        nrst,          // sync reset, active low
    input wire        hsel,          // ahb select
    input wire [1:0]  htrans,        // ahb transfer type
    input wire        hwrite,        // ahb write
    input wire        hready,        // ahb bus ready
    input wire        hreadyout,     // slave ready
    input wire        hresp,         // slave response
    input wire        desc_take,     // descriptor consumed
    input wire        wait_done_if,  // wait completion
    input wire        fetch_req,     // descriptors pending
    input wire [63:0] fetch_addr,    // descriptor address
    input wire        queue_error,   // queue error level
    input wire        wait_done_new  // new completion pulse
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    reg wr_ph_ff;
    // queue_error and fetch_req may only rise after a write data phase
    always @(posedge mclk) wr_ph_ff <= nrst && hsel && hready && htrans[1] && hwrite;
    sequence wdone_s;
        wait_done_new ##1 !wait_done_new;
    endsequence
    bus_okay_a: assert property (!hresp)
        else $error("bus answer not okay");
    read_wait_a: assert property (!hreadyout |=> hreadyout)
        else $error("wait state longer than one cycle");
    err_blocks_a: assert property (queue_error |-> !fetch_req)
        else $error("fetch requested during queue error");
    wdone_cause_a: assert property (wait_done_new |-> $past(wait_done_if))
        else $error("completion pulse without completion");
    wdone_once_a: assert property (wait_done_new |-> wdone_s)
        else $error("completion pulse longer than one cycle");
    addr_align_a: assert property (fetch_addr[3:0] == 4'h0)
        else $error("descriptor address not aligned");
    err_by_write_a: assert property ($rose(queue_error) |-> $past(wr_ph_ff))
        else $error("queue error without a write");
    fetch_hold_a: assert property (fetch_req && !desc_take && !wr_ph_ff |=> fetch_req)
        else $error("fetch request dropped without cause");
    fetch_rise_a: assert property ($rose(fetch_req) |-> $past(wr_ph_ff))
        else $error("fetch request without a write");
endmodule

bind iqr_regs iqr_regs_sva u_sva (.mclk, .nrst, .hsel, .htrans, .hwrite, .hready, .hreadyout,
    .hresp, .desc_take, .wait_done_if, .fetch_req, .fetch_addr, .queue_error, .wait_done_new);

// ### tb/iqr_regs_bench.sv
`include "iqr_defs.vh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
    $display("Error %s exp %h got %h", nm, e, g); end end

module iqr_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic        desc_take = 1'b0, wait_done_if = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, rd_off;
    logic        nw;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    wire  [31:0] hrdata;
    wire  [63:0] fetch_addr;
    wire         hreadyout, hresp, fetch_req, queue_error, wait_done_new;
    wire  [31:0] hrdata_off;
    wire         qerr_smt, wnew_off;
    integer      n_errors = 0, checks = 0;

    always #10 mclk = ~mclk;

    iqr_regs #(.QI_SUPPORT(1), .SMT_SUPPORT(0), .ADM_SUPPORT(0), .HOST_ADDRESS_WIDTH(48)) uut (
        .mclk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hrdata, .hreadyout, .hresp, .desc_take, .wait_done_if, .fetch_req, .fetch_addr,
        .queue_error, .wait_done_new);

    // same bus, other build options: wide descriptors allowed / no queued invalidation
    iqr_regs #(.QI_SUPPORT(1), .SMT_SUPPORT(1), .ADM_SUPPORT(0), .HOST_ADDRESS_WIDTH(48)) uut_smt (
        .mclk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hrdata(), .hreadyout(), .hresp(), .desc_take, .wait_done_if, .fetch_req(),
        .fetch_addr(), .queue_error(qerr_smt), .wait_done_new());
    iqr_regs #(.QI_SUPPORT(0), .SMT_SUPPORT(0), .ADM_SUPPORT(0), .HOST_ADDRESS_WIDTH(48)) uut_off (
        .mclk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hrdata(hrdata_off), .hreadyout(), .hresp(), .desc_take, .wait_done_if,
        .fetch_req(), .fetch_addr(), .queue_error(), .wait_done_new(wnew_off));

    task automatic stop_test;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic wait_rdy;
        integer n;
        n = 0;
        // look mid-cycle: ready and read data are settled and stand through the edge
        @(negedge mclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 100) begin
                n_errors++;
                stop_test;
            end
            @(negedge mclk);
        end
        rd = hrdata;
        rd_off = hrdata_off;
        @(posedge mclk);
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= `IQR_HTRANS_NONSEQ;
        hwrite <= w;
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        #1;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        `CHK("hrdata", e, rd)
    endtask

    task automatic pulse(input logic take, output logic seen);
        @(posedge mclk);
        if (take) desc_take <= 1'b1;
        else wait_done_if <= 1'b1;
        @(posedge mclk);
        desc_take <= 1'b0;
        wait_done_if <= 1'b0;
        // completion pulse stands for this one cycle only
        #1 seen = wait_done_new;
        @(posedge mclk);
        #1;
    endtask

    task automatic t_reset;
        logic [7:0] adr [0:7] = '{8'h80, 8'h84, 8'h88, 8'h8c, 8'h90, 8'h94, 8'h9c, 8'h40};
        foreach (adr[i]) rd_chk(adr[i], 32'h0);
    endtask

    task automatic t_fields;
        xfer(1'b1, `IQR_OFF_TAIL_LO, 32'hffffffff);
        rd_chk(`IQR_OFF_TAIL_LO, 32'h0007fff0);
        xfer(1'b1, `IQR_OFF_TAIL_HI, 32'hffffffff);
        rd_chk(`IQR_OFF_TAIL_HI, 32'h0);
        xfer(1'b1, `IQR_OFF_BASE_LO, 32'habcde7fb);
        rd_chk(`IQR_OFF_BASE_LO, 32'habcde003);
        xfer(1'b1, `IQR_OFF_BASE_HI, 32'h00001234);
        rd_chk(`IQR_OFF_BASE_HI, 32'h00001234);
        xfer(1'b1, `IQR_OFF_TAIL_LO, 32'h0);
    endtask

    task automatic t_fetch;
        xfer(1'b1, `IQR_OFF_CTRL, 32'h1);
        xfer(1'b1, `IQR_OFF_TAIL_LO, 32'h20);
        `CHK("fetch_req", 1'b1, fetch_req)
        `CHK("fetch_addr", 64'h00001234abcde000, fetch_addr)
        pulse(1'b1, nw);
        `CHK("fetch_addr", 64'h00001234abcde010, fetch_addr)
        pulse(1'b1, nw);
        `CHK("fetch_req", 1'b0, fetch_req)
        rd_chk(`IQR_OFF_STAT, 32'h5);
        rd_chk(`IQR_OFF_HEAD_LO, 32'h20);
        xfer(1'b1, `IQR_OFF_CTRL, 32'h0);
        rd_chk(`IQR_OFF_HEAD_LO, 32'h0);
    endtask

    task automatic t_err;
        // base and width only rewritten while the queue is disabled
        xfer(1'b1, `IQR_OFF_BASE_LO, 32'habcde803);
        xfer(1'b1, `IQR_OFF_CTRL, 32'h1);
        `CHK("queue_error", 1'b1, queue_error)
        `CHK("fetch_req", 1'b0, fetch_req)
        rd_chk(`IQR_OFF_BASE_LO, 32'habcde803);
        rd_chk(`IQR_OFF_STAT, 32'h3);
        xfer(1'b1, `IQR_OFF_CTRL, 32'h0);
        `CHK("queue_error", 1'b0, queue_error)
    endtask

    task automatic t_wdone;
        pulse(1'b0, nw);
        `CHK("wait_done_new", 1'b1, nw)
        rd_chk(`IQR_OFF_CMPL, 32'h1);
        pulse(1'b0, nw);
        `CHK("wait_done_new", 1'b0, nw)
        xfer(1'b1, `IQR_OFF_CMPL, 32'h0);
        rd_chk(`IQR_OFF_CMPL, 32'h1);
        xfer(1'b1, `IQR_OFF_CMPL, 32'h1);
        rd_chk(`IQR_OFF_CMPL, 32'h0);
    endtask

    task automatic t_alt;
        xfer(1'b1, `IQR_OFF_CTRL, 32'h1);
        `CHK("qerr_smt", 1'b0, qerr_smt)
        `CHK("queue_error", 1'b1, queue_error)
        xfer(1'b1, `IQR_OFF_TAIL_LO, 32'h10);
        `CHK("qerr_smt", 1'b1, qerr_smt)
        rd_chk(`IQR_OFF_TAIL_LO, 32'h10);
        `CHK("hrdata_off", 32'h0, rd_off)
        rd_chk(`IQR_OFF_BASE_LO, 32'habcde803);
        `CHK("hrdata_off", 32'h0, rd_off)
        pulse(1'b0, nw);
        `CHK("wait_done_new", 1'b1, nw)
        rd_chk(`IQR_OFF_CMPL, 32'h1);
        `CHK("hrdata_off", 32'h0, rd_off)
        xfer(1'b1, `IQR_OFF_CTRL, 32'h0);
    endtask

    initial begin
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        t_reset;
        t_fields;
        t_fetch;
        t_err;
        t_wdone;
        t_alt;
        stop_test;
    end
endmodule
